/* src/mca_pkg.sv */
// package: codes, event carriers, states and timing of the message collision arbiter
`default_nettype none
package mca_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int GAP_TIME_MS = 50; // terminal silence after an abort code
  localparam int GAP_CYC = GAP_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int GAP_W = 24;

  // ****************************************
  // storage
  // ****************************************
  localparam int IN_SLOTS = 2; // inbound double buffer
  localparam int IN_CNT_W = 2;
  localparam int CODE_DEPTH = 2; // entries of the code buffer

  // ****************************************
  // types
  // ****************************************
  // codes sent to the data terminal
  typedef enum logic [1:0] {
    MCA_ACCEPT, // transfer_accept_reply
    MCA_ABORT, // abort_code
    MCA_DONE, // second_completion_code
    MCA_BEGIN // transfer_begin_request
  } mca_code_t;

  // outbound message handling
  typedef enum logic [1:0] {OB_IDLE, OB_XFER, OB_HOLD, OB_DOOM} mca_ob_t;

  // one-cycle events decoded from the data terminal link
  typedef struct packed {
    logic xfer_begin; // terminal sent transfer_begin_request
    logic accept; // terminal sent transfer_accept_reply
    logic out_done; // last outbound byte received from terminal
    logic in_done; // last inbound byte delivered to terminal
  } mca_term_evt_t;

  // one-cycle events decoded from the radio control port
  typedef struct packed {
    logic in_start; // radio begins an inbound message
    logic in_done; // inbound message fully received
    logic out_refused; // outbound refused, radio already receiving
    logic out_abandon; // outbound abandoned for a channel assignment
    logic out_done; // outbound call finished
    logic out_ok; // with out_done: call completed normally
  } mca_radio_evt_t;
endpackage
`default_nettype wire

/* src/mca_buf.sv */
// small register buffer with valid/ready on both sides
`default_nettype none
module mca_buf #(
  parameter int W = 2,
  parameter int DEPTH = mca_pkg::CODE_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import mca_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("mca_buf: DEPTH must be a power of two of at least 2");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire [AW:0] fill = wr_ptr - rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // flags from the pointer distance, so full and empty never lie
  assign in_ready = fill != (AW + 1)'(DEPTH);
  assign out_valid = fill != '0;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // pointers
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW + 1)'(push);
      rd_ptr <= rd_ptr + (AW + 1)'(pop);
    end
  end

  // storage, written only on an accepted push
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end

  AST_BUF_HOLD: assert property (@(posedge clk) disable iff (srst)
    out_valid && !out_ready |=> out_valid && $stable(out_data)) else $error("buffer head moved while stalled");
endmodule
`default_nettype wire

/* src/mca_arbiter.sv */
// message collision arbiter between data terminal and radio control port
`default_nettype none
// Function
// - terminal priority: refused outbound finishes, then aborts
// - inbound request only after radio data complete
// - outbound during inbound reception handled as collision
// - early internal collision: accept outbound, buffer inbound
// - completion code then inbound transfer request
// - request after completion code: device keeps priority
// - channel assignment: keep outbound, receive inbound
// - retry buffered outbound after inbound completes
// - retried call ends: completion code, then request
// - second abandonment: abort code, then inbound request
// - refused while receiving: hold outbound, retry later
// - two inbound slots, accept second during delivery
// - terminal priority collision: accept, store inbound
// - terminal silent after abort; device request fits
// - collision inside device resolved as request collision
module mca_arbiter #(
  parameter int GAP_CYC = mca_pkg::GAP_CYC
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic prio_dev_pin,
  input wire mca_pkg::mca_term_evt_t term_evt,
  input wire mca_pkg::mca_radio_evt_t radio_evt,
  output logic evt_ready,
  output logic code_valid,
  input wire logic code_ready,
  output mca_pkg::mca_code_t code,
  output logic radio_out_start,
  output logic term_deliver_start,
  output logic radio_in_reject,
  output logic [mca_pkg::IN_CNT_W-1:0] in_count,
  output logic out_busy,
  output logic gap_active
);
  import mca_pkg::*;

  if (GAP_CYC < 1 || GAP_CYC >= (1 << GAP_W)) begin : g_bad_gap
    $error("mca_arbiter: GAP_CYC out of range");
  end

  // ****************************************
  // strap synchroniser and event gating
  // ****************************************
  logic mode_meta;
  logic prio_dev;
  // strap comes from a pin, so two flops before use
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_meta <= 1'b0;
      prio_dev <= 1'b0;
    end else begin
      mode_meta <= prio_dev_pin;
      prio_dev <= mode_meta;
    end
  end

  logic code_push_ready;
  // events are only taken while a code can be queued; a full buffer stalls both links
  wire go = code_push_ready;
  assign evt_ready = go;
  wire t_begin = go && term_evt.xfer_begin;
  wire t_accept = go && term_evt.accept;
  wire t_out_done = go && term_evt.out_done;
  wire t_in_done = go && term_evt.in_done;
  wire r_in_start = go && radio_evt.in_start;
  wire r_in_done = go && radio_evt.in_done;
  wire r_fail = go && (radio_evt.out_refused || radio_evt.out_abandon);
  wire r_out_done = go && radio_evt.out_done;

  // ****************************************
  // state
  // ****************************************
  mca_ob_t ob_state;
  mca_ob_t next_ob_state;
  logic term_done;
  logic tries;
  logic in_rx;
  logic dev_pend;
  logic delivering;
  logic [GAP_W-1:0] gap_cnt;

  // ****************************************
  // decisions
  // ****************************************
  wire ob_idle = ob_state == OB_IDLE;
  wire ob_xfer = ob_state == OB_XFER;
  wire term_complete = term_done || t_out_done;
  // a terminal request is taken when idle and not delivering, unless a device request holds priority or the gap runs
  wire accept_term = t_begin && ob_idle && !delivering && !gap_active && !(prio_dev && dev_pend);
  wire emit_done = ob_xfer && r_out_done;
  // terminal priority always, device priority on the second failure: abort
  wire fail_to_doom = !prio_dev || tries;
  wire doom_abort = !r_out_done && term_complete
    && (ob_state == OB_DOOM || (ob_xfer && r_fail && fail_to_doom));
  // retry only once the radio has finished handing over the inbound message
  wire retry = ob_state == OB_HOLD && term_complete && !in_rx && !r_in_start;
  // completed inbound slots only, so arriving data never gets announced early
  wire issue_begin = go && in_count != '0 && ob_idle && !dev_pend && !delivering && !t_begin;
  wire slot_free = in_count < IN_CNT_W'(IN_SLOTS);

  wire code_in_valid = accept_term || emit_done || doom_abort || issue_begin;
  wire mca_code_t code_in = accept_term ? MCA_ACCEPT
    : emit_done ? (radio_evt.out_ok ? MCA_DONE : MCA_ABORT)
    : doom_abort ? MCA_ABORT : MCA_BEGIN;
  wire abort_sent = code_in_valid && code_in == MCA_ABORT;

  // outbound transitions
  always_comb begin
    next_ob_state = ob_state;
    case (ob_state)
      OB_IDLE: begin
        if (accept_term) next_ob_state = OB_XFER;
      end
      OB_XFER: begin
        if (emit_done || doom_abort) next_ob_state = OB_IDLE;
        else if (r_fail) next_ob_state = fail_to_doom ? OB_DOOM : OB_HOLD;
      end
      OB_HOLD: begin
        if (retry) next_ob_state = OB_XFER;
      end
      OB_DOOM: begin
        if (doom_abort) next_ob_state = OB_IDLE;
      end
      default: next_ob_state = OB_IDLE;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  // outbound side
  always_ff @(posedge clk) begin
    if (srst) begin
      ob_state <= OB_IDLE;
      term_done <= 1'b0;
      tries <= 1'b0;
      radio_out_start <= 1'b0;
    end else begin
      ob_state <= next_ob_state;
      term_done <= accept_term ? 1'b0 : term_complete; // remembers the whole terminal message is in, until the next accept
      tries <= accept_term ? 1'b0 : (tries || retry);
      radio_out_start <= accept_term || retry;
    end
  end

  // inbound slots, radio reception and delivery to the terminal
  always_ff @(posedge clk) begin
    if (srst) begin
      in_count <= '0;
      in_rx <= 1'b0;
      radio_in_reject <= 1'b0;
      dev_pend <= 1'b0;
      delivering <= 1'b0;
      term_deliver_start <= 1'b0;
    end else begin
      in_count <= in_count + IN_CNT_W'(r_in_done && in_rx) - IN_CNT_W'(t_in_done && delivering);
      in_rx <= (in_rx && !r_in_done) || (r_in_start && slot_free);
      radio_in_reject <= r_in_start && !slot_free;
      // terminal priority withdraws our request on a collision
      dev_pend <= issue_begin || (dev_pend && !t_accept && !(accept_term && !prio_dev));
      delivering <= (delivering && !t_in_done) || (dev_pend && t_accept);
      term_deliver_start <= dev_pend && t_accept;
    end
  end

  // silence window after each abort code
  always_ff @(posedge clk) begin
    if (srst) gap_cnt <= '0;
    else if (abort_sent) gap_cnt <= GAP_W'(GAP_CYC);
    else if (gap_cnt != '0) gap_cnt <= gap_cnt - GAP_W'(1);
  end

  assign gap_active = gap_cnt != '0;
  assign out_busy = !ob_idle;

  // ****************************************
  // code buffer toward the terminal
  // ****************************************
  logic [$bits(mca_code_t)-1:0] code_raw;
  mca_buf #(.W($bits(mca_code_t)), .DEPTH(CODE_DEPTH)) u_code_buf (
    .clk(clk),
    .srst(srst),
    .in_valid(code_in_valid),
    .in_ready(code_push_ready),
    .in_data(code_in),
    .out_valid(code_valid),
    .out_ready(code_ready),
    .out_data(code_raw)
  );
  assign code = mca_code_t'(code_raw);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_REFUSED_ABORT: assert property (ob_state == OB_DOOM && t_out_done && !r_out_done
    |-> code_in_valid && code_in == MCA_ABORT ##1 ob_idle && gap_active) else $error("doomed outbound not aborted");
  AST_BEGIN_AFTER_DATA: assert property (code_in_valid && code_in == MCA_BEGIN
    |-> in_count != '0 && ob_idle) else $error("inbound request without complete message");
  AST_COMPLETION: assert property (ob_xfer && r_out_done
    |-> code_in_valid && code_in == (radio_evt.out_ok ? MCA_DONE : MCA_ABORT) ##1 ob_idle)
    else $error("completion code missing");
  AST_DEV_KEEPS_PRIO: assert property (prio_dev && dev_pend && t_begin && !t_accept
    |=> !radio_out_start && dev_pend && ob_idle) else $error("device priority lost");
  AST_HOLD_ON_FIRST_FAIL: assert property (prio_dev && ob_xfer && !tries && r_fail && !r_out_done
    |=> ob_state == OB_HOLD) else $error("first failure did not hold outbound");
  AST_RETRY: assert property (ob_state == OB_HOLD && term_done && !in_rx && !r_in_start
    |=> radio_out_start && tries ##1 !radio_out_start) else $error("held outbound not retried");
  AST_SECOND_FAIL: assert property (prio_dev && ob_xfer && tries && r_fail && !r_out_done && term_done
    |-> code_in_valid && code_in == MCA_ABORT) else $error("second failure not aborted");
  AST_HOLD_WAITS: assert property (ob_state == OB_HOLD && in_rx
    |=> !radio_out_start) else $error("retry during inbound reception");
  AST_DOUBLE_BUF: assert property (r_in_start && in_count == IN_CNT_W'(1) && !in_rx
    |=> in_rx && !radio_in_reject) else $error("second inbound message refused");
  AST_ACCEPT: assert property (t_begin && ob_idle && !delivering && !gap_active && !prio_dev
    |-> code_in_valid && code_in == MCA_ACCEPT ##1 radio_out_start && !dev_pend) else $error("terminal not accepted");
  AST_GAP: assert property (abort_sent |=> gap_active [*8]) else $error("gap shorter than expected");
  AST_STORAGE: assert property (in_count <= IN_CNT_W'(IN_SLOTS)) else $error("inbound slots overrun");

  COV_COLLISION: cover property (dev_pend && t_begin);
  COV_RETRY_DONE: cover property (retry ##[1:50] emit_done);
  COV_TWO_SLOTS: cover property (in_count == IN_CNT_W'(2));
endmodule
`default_nettype wire

/* verif/mca_term_model.sv */
// data terminal model: takes codes, logs them, answers a begin request
`default_nettype none
module mca_term_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic stall,
  input wire logic code_valid,
  input wire mca_pkg::mca_code_t code,
  output logic code_ready,
  output logic acc
);
  timeunit 1ns;
  timeprecision 1ps;
  import mca_pkg::*;
  mca_code_t log_q[$];
  // a stalled terminal leaves codes standing in the device's buffer
  assign code_ready = !stall;
  // a begin request is always accepted, any own request is withdrawn
  always @(posedge clk) begin
    acc <= 1'b0;
    if (srst) begin
      log_q.delete();
    end else if (code_valid && code_ready) begin
      log_q.push_back(code);
      acc <= (code == MCA_BEGIN);
    end
  end
endmodule
`default_nettype wire

/* verif/tb_mca_arbiter.sv */
// self-checking bench of the message collision arbiter
`default_nettype none
module tb_mca_arbiter;
  timeunit 1ns;
  timeprecision 1ps;
  import mca_pkg::*;
  logic clk, srst, prio_dev_pin, stall, acc;
  logic evt_ready, code_valid, code_ready;
  logic radio_out_start, term_deliver_start, radio_in_reject, out_busy, gap_active;
  logic [3:0] te;
  logic [1:0] in_count;
  mca_code_t code;
  mca_term_evt_t term_evt;
  mca_radio_evt_t radio_evt;
  int n_fail, cmp_count, n_st, n_dl, n_rj;
  // the model's accept reply joins the bench's own terminal events
  assign term_evt = te | {1'b0, acc, 2'b00};
  mca_arbiter #(.GAP_CYC(20)) dut (.clk, .srst, .prio_dev_pin, .term_evt, .radio_evt, .evt_ready,
    .code_valid, .code_ready, .code, .radio_out_start, .term_deliver_start, .radio_in_reject,
    .in_count, .out_busy, .gap_active);
  mca_term_model tm (.clk, .srst, .stall, .code_valid, .code, .code_ready, .acc);
  always #2 clk = ~clk;
  // pulse counters; scenarios clear them only while nothing is pending
  always @(posedge clk) begin
    if (radio_out_start === 1'b1) n_st++;
    if (term_deliver_start === 1'b1) n_dl++;
    if (radio_in_reject === 1'b1) n_rj++;
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task close_out;
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // bounded wait for the terminal to take the next code
  task automatic chk_code(input mca_code_t exp);
    int i;
    mca_code_t g;
    i = 0;
    g = mca_code_t'(2'bxx);
    while (tm.log_q.size() == 0 && i < 300) begin
      @(posedge clk);
      i++;
    end
    if (tm.log_q.size() != 0) g = tm.log_q.pop_front();
    cmp_count++;
    if (g !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %0h exp %0h", $time, g, exp);
    end
  endtask
  task automatic wcyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // events are held until an edge with evt_ready high takes them
  task automatic ev(input logic [3:0] t, input logic [5:0] r);
    @(posedge clk);
    te <= t;
    radio_evt <= r;
    @(posedge clk);
    while (evt_ready !== 1'b1) @(posedge clk);
    te <= 4'h0;
    radio_evt <= 6'h00;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task s_tp_collision;
    ev(4'h0, 6'h20);
    ev(4'h8, 6'h00);
    chk_code(MCA_ACCEPT);
    ev(4'h0, 6'h10);
    wcyc(2);
    chk_val(8'(in_count), 8'h01);
    stall <= 1'b1;
    ev(4'h2, 6'h00);
    ev(4'h0, 6'h03);
    wcyc(4);
    chk_val(8'(evt_ready), 8'h00);
    stall <= 1'b0;
    chk_code(MCA_DONE);
    chk_code(MCA_BEGIN);
    wcyc(4);
    chk_val(8'(n_dl), 8'h01);
    ev(4'h1, 6'h00);
    wcyc(2);
    chk_val(8'(in_count), 8'h00);
  endtask
  task s_tp_refused;
    ev(4'h8, 6'h00);
    chk_code(MCA_ACCEPT);
    ev(4'h0, 6'h20);
    ev(4'h0, 6'h08);
    wcyc(4);
    chk_val(8'(tm.log_q.size()), 8'h00);
    ev(4'h2, 6'h00);
    chk_code(MCA_ABORT);
    chk_val(8'(gap_active), 8'h01);
    ev(4'h8, 6'h00);
    wcyc(4);
    chk_val(8'(tm.log_q.size()), 8'h00);
    ev(4'h0, 6'h10);
    chk_code(MCA_BEGIN);
    wcyc(4);
    ev(4'h1, 6'h00);
    wcyc(30);
  endtask
  task s_dp_abandon;
    ev(4'h8, 6'h00);
    chk_code(MCA_ACCEPT);
    wcyc(2);
    n_st = 0;
    ev(4'h0, 6'h04);
    ev(4'h0, 6'h20);
    ev(4'h2, 6'h00);
    wcyc(3);
    chk_val({n_st[6:0], out_busy}, 8'h01);
    ev(4'h0, 6'h10);
    wcyc(3);
    chk_val(8'(n_st), 8'h01);
    ev(4'h0, 6'h04);
    chk_code(MCA_ABORT);
    chk_code(MCA_BEGIN);
    wcyc(4);
    ev(4'h1, 6'h00);
    wcyc(30);
  endtask
  task s_dp_refused;
    ev(4'h8, 6'h00);
    chk_code(MCA_ACCEPT);
    wcyc(2);
    n_st = 0;
    ev(4'h0, 6'h20);
    ev(4'h0, 6'h08);
    ev(4'h2, 6'h00);
    wcyc(3);
    chk_val(8'(n_st), 8'h00);
    ev(4'h0, 6'h10);
    wcyc(3);
    chk_val(8'(n_st), 8'h01);
    ev(4'h0, 6'h03);
    chk_code(MCA_DONE);
    chk_code(MCA_BEGIN);
    wcyc(4);
    ev(4'h1, 6'h00);
  endtask
  task s_double;
    ev(4'h0, 6'h20);
    ev(4'h0, 6'h10);
    chk_code(MCA_BEGIN);
    wcyc(3);
    ev(4'h0, 6'h20);
    ev(4'h0, 6'h10);
    wcyc(2);
    chk_val(8'(in_count), 8'h02);
    n_rj = 0;
    ev(4'h0, 6'h20);
    wcyc(3);
    chk_val(8'(n_rj), 8'h01);
    ev(4'h1, 6'h00);
    chk_code(MCA_BEGIN);
    wcyc(4);
    ev(4'h1, 6'h00);
    wcyc(2);
    chk_val(8'(in_count), 8'h00);
  endtask
  // device priority: terminal request against a standing device request, then a fresh one
  task s_dp_collision;
    n_st = 0;
    stall <= 1'b1;
    ev(4'h0, 6'h20);
    ev(4'h0, 6'h10);
    ev(4'h8, 6'h00); // colliding request, withdrawn by the terminal
    wcyc(3);
    chk_val({n_st[6:0], out_busy}, 8'h00);
    stall <= 1'b0;
    chk_code(MCA_BEGIN);
    wcyc(4);
    chk_val(8'(tm.log_q.size()), 8'h00);
    ev(4'h1, 6'h00);
    ev(4'h8, 6'h00); // fresh request only after delivery
    chk_code(MCA_ACCEPT);
    ev(4'h2, 6'h00);
    ev(4'h0, 6'h03);
    chk_code(MCA_DONE);
    wcyc(2);
    chk_val(8'(in_count), 8'h00);
  endtask
  // main sequence: terminal priority first, then the strap turns to device priority
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    prio_dev_pin = 1'b0;
    stall = 1'b0;
    te = 4'h0;
    radio_evt = 6'h00;
    wcyc(3);
    srst <= 1'b0;
    wcyc(3);
    chk_val(8'({in_count, code_valid, out_busy, gap_active, evt_ready}), 8'h01);
    s_tp_collision;
    s_tp_refused;
    prio_dev_pin <= 1'b1;
    wcyc(4);
    s_dp_abandon;
    s_dp_refused;
    s_double;
    s_dp_collision;
    close_out;
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    #80000;
    n_fail++;
    close_out;
  end
endmodule
`default_nettype wire
